//--- logic/trs_pkg.sv
package trs_pkg;
  // Clock and timing
  localparam int unsigned CLOCK_PERIOD_PS = 5000;
  localparam int unsigned SETTLE_TIME_NS = 100;
  localparam int unsigned SETTLE_CYCLES =
    (SETTLE_TIME_NS * 1000 + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  localparam int unsigned BSYNC_MIN_CLOCKS = 3;
  localparam int unsigned SUBFRAMES_PER_BLOCK = 384;

  // APB register map (byte addresses)
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [7:0] IDREV_OFFSET = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_RUN_BIT = 0;
  localparam int unsigned CTRL_BSYNC_OUT_BIT = 1;
  localparam int unsigned CTRL_AV_IN_BIT = 2;
  localparam int unsigned CTRL_PC_IN_BIT = 3;
  localparam int unsigned CTRL_EU_IN_BIT = 4;
  localparam int unsigned CTRL_WIDTH = 5;
  localparam logic [CTRL_WIDTH-1:0] CTRL_RESET = 5'h00;

  // Status and identity field positions
  localparam int unsigned STATUS_STATE_LSB = 0;
  localparam int unsigned STATUS_STRAP_LSB = 4;
  localparam int unsigned STATUS_HWMODE_BIT = 6;
  localparam int unsigned STATUS_MASTER_BIT = 7;
  localparam int unsigned IDREV_REV_LSB = 0;
  localparam int unsigned IDREV_ID_LSB = 4;

  // Category group whose generation bit has inverted sense
  localparam logic [7:0] CAT_GROUP_MASK = 8'h07;
  localparam logic [7:0] CAT_INVERT_GROUP = 8'h01;

  // Received channel status bits of interest
  typedef struct packed {
    logic audio_flag;
    logic pro_flag;
    logic emphasis_strap_pin_none;
    logic [7:0] category;
    logic gen_bit;
  } trs_rx_cs_t;

  // Start-up option levels
  typedef struct packed {
    logic original_recording_flag;
    logic emphasis_strap_pin;
  } trs_strap_t;

  typedef enum logic [1:0] {
    ST_LOW_POWER,
    ST_SETTLE,
    ST_RUN
  } trs_state_t;
endpackage

//--- logic/trs_top.sv
`timescale 1ns/1ps
module trs_top
  import trs_pkg::*;
#(
  parameter int unsigned SAMPLE_W = 24,
  parameter int unsigned BIT_HALF_CYCLES = 4,
  parameter int unsigned BITS_PER_SUBFRAME = 32,
  parameter logic [3:0] ID_CODE = 4'hA, // Arbitrary value
  parameter logic [3:0] REV_CODE = 4'h1 // Arbitrary value
) (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_reset,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // Mode straps and receiver state
  input wire logic i_hw_mode_select,
  input wire logic i_input_port_role_select,
  input wire logic i_pll_locked,
  input wire trs_rx_cs_t i_rx_cs,
  // Transmit data
  input wire logic [SAMPLE_W-1:0] i_tx_sample,
  input wire logic i_tx_line_data,
  // Block sync pin
  input wire logic i_cs_block_sync_pin,
  output logic o_cs_block_sync_pin,
  output logic o_cs_block_sync_pin_oe,
  // Channel status dual-role pins
  input wire logic i_audio_or_validity_pin,
  output logic o_audio_or_validity_pin,
  output logic o_audio_or_validity_pin_oe,
  input wire logic i_pro_flag_or_cbit_pin,
  output logic o_pro_flag_or_cbit_pin,
  output logic o_pro_flag_or_cbit_pin_oe,
  input wire logic i_emphasis_or_user_bit_pin,
  output logic o_emphasis_or_user_bit_pin,
  output logic o_emphasis_or_user_bit_pin_oe,
  input wire logic i_original_recording_flag,
  output logic o_original_recording_flag,
  output logic o_original_recording_flag_oe,
  // Serial audio output
  output logic o_output_word_clock,
  output logic o_output_bit_clock,
  output logic o_serial_audio_out,
  // Line drivers
  output logic o_line_driver_p,
  output logic o_line_driver_n,
  // Sampled transmit bits and mode results
  output logic o_tx_validity,
  output logic o_tx_cbit,
  output logic o_tx_ubit,
  output logic o_low_power,
  output logic o_input_port_master,
  output logic o_chip_addr_bit,
  output trs_strap_t o_hw_straps
);

  localparam int unsigned BLK_W = $clog2(SUBFRAMES_PER_BLOCK);
  localparam int unsigned DIV_W = $clog2(BIT_HALF_CYCLES + 1);
  localparam int unsigned BIT_W = $clog2(BITS_PER_SUBFRAME);
  localparam int unsigned SET_W = $clog2(SETTLE_CYCLES + 1);
  localparam int unsigned BS_W = $clog2(BSYNC_MIN_CLOCKS + 1);

  logic [CTRL_WIDTH-1:0] ctrl_q;
  trs_state_t state_q;
  logic [SET_W-1:0] settle_q;
  logic strap_done_q;
  trs_strap_t strap_q;
  logic [DIV_W-1:0] div_q;
  logic bclk_q;
  logic [BIT_W-1:0] bit_q;
  logic wclk_q;
  logic [SAMPLE_W-1:0] shift_q;
  logic [BLK_W-1:0] subframe_q;
  logic [BS_W-1:0] bs_count_q;
  logic bs_pending_q;
  logic running;
  logic bclk_fall;
  logic subframe_start;
  logic apb_write;
  logic apb_setup;
  logic addr_ok;
  logic bsync_out;
  logic av_in;
  logic pc_in;
  logic eu_in;

  // Generation bit sense flips for one category group
  function automatic logic decode_original(input trs_rx_cs_t cs);
    if ((cs.category & CAT_GROUP_MASK) == CAT_INVERT_GROUP) begin
      return cs.gen_bit;
    end
    return ~cs.gen_bit;
  endfunction

  // Pin roles: hardware mode takes them from straps, not the control port
  assign running = (state_q == ST_RUN);
  assign bsync_out = i_hw_mode_select ? strap_q.original_recording_flag : ctrl_q[CTRL_BSYNC_OUT_BIT];
  assign av_in = i_hw_mode_select ? strap_q.original_recording_flag : ctrl_q[CTRL_AV_IN_BIT];
  assign pc_in = i_hw_mode_select ? strap_q.original_recording_flag : ctrl_q[CTRL_PC_IN_BIT];
  assign eu_in = i_hw_mode_select ? strap_q.original_recording_flag : ctrl_q[CTRL_EU_IN_BIT];

  // APB decode; no wait states, so pready is constant high
  assign apb_setup = i_psel && !i_penable;
  assign apb_write = i_psel && i_penable && i_pwrite && !o_pslverr;
  assign addr_ok = (i_paddr == CTRL_OFFSET) || (i_paddr == STATUS_OFFSET) ||
                   (i_paddr == IDREV_OFFSET);
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable &&
                     (!addr_ok || (i_pwrite && i_hw_mode_select));

  // Control register; cleared by reset
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ctrl_q <= CTRL_RESET;
    end else if (apb_write && i_paddr == CTRL_OFFSET) begin
      ctrl_q <= i_pwdata[CTRL_WIDTH-1:0];
    end
  end

  // Read data captured in the setup phase so it is a flop in the access phase
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_prdata <= 32'h0000_0000;
    end else if (apb_setup) begin
      o_prdata <= 32'h0000_0000;
      case (i_paddr)
        CTRL_OFFSET: o_prdata[CTRL_WIDTH-1:0] <= ctrl_q;
        STATUS_OFFSET: begin
          o_prdata[STATUS_STATE_LSB +: 2] <= state_q;
          o_prdata[STATUS_STRAP_LSB +: 2] <= strap_q;
          o_prdata[STATUS_HWMODE_BIT] <= i_hw_mode_select;
          o_prdata[STATUS_MASTER_BIT] <= i_input_port_role_select;
        end
        IDREV_OFFSET: begin
          o_prdata[IDREV_ID_LSB +: 4] <= ID_CODE;
          o_prdata[IDREV_REV_LSB +: 4] <= REV_CODE;
        end
        default: o_prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Power state: hardware mode starts itself, software waits for run
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_q <= ST_LOW_POWER;
      settle_q <= '0;
    end else begin
      case (state_q)
        ST_LOW_POWER: begin
          settle_q <= '0;
          if (ctrl_q[CTRL_RUN_BIT] || (i_hw_mode_select && strap_done_q)) begin
            state_q <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          // Lock must hold for the whole settle time; a dropout restarts it
          if (!i_pll_locked) begin
            settle_q <= '0;
          end else if (settle_q == SET_W'(SETTLE_CYCLES - 1)) begin
            state_q <= ST_RUN;
          end else begin
            settle_q <= settle_q + SET_W'(1);
          end
        end
        ST_RUN: begin
          if (!ctrl_q[CTRL_RUN_BIT] && !i_hw_mode_select) begin
            state_q <= ST_LOW_POWER;
          end
        end
        default: state_q <= ST_LOW_POWER;
      endcase
    end
  end
  assign o_low_power = (state_q == ST_LOW_POWER);

  // Strap capture on the first clock after reset release, then held
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      strap_done_q <= 1'b0;
      strap_q <= '0;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      strap_q.emphasis_strap_pin <= i_emphasis_or_user_bit_pin;
      strap_q.original_recording_flag <= i_original_recording_flag;
    end
  end
  assign o_hw_straps = strap_q;
  assign o_chip_addr_bit = i_hw_mode_select ? 1'b0 : strap_q.emphasis_strap_pin;
  assign o_input_port_master = i_input_port_role_select;

  // Bit clock divider and word clock; stopped and low while not running
  assign bclk_fall = running && bclk_q && (div_q == DIV_W'(BIT_HALF_CYCLES - 1));
  assign subframe_start = bclk_fall && (bit_q == BIT_W'(BITS_PER_SUBFRAME - 1));
  always_ff @(posedge i_clock) begin
    if (i_reset || !running) begin
      div_q <= '0;
      bclk_q <= 1'b0;
      bit_q <= '0;
      wclk_q <= 1'b0;
    end else if (div_q == DIV_W'(BIT_HALF_CYCLES - 1)) begin
      div_q <= '0;
      bclk_q <= ~bclk_q;
      if (bclk_q) begin
        bit_q <= bit_q + BIT_W'(1);
        if (subframe_start) begin
          wclk_q <= ~wclk_q;
        end
      end
    end else begin
      div_q <= div_q + DIV_W'(1);
    end
  end
  assign o_output_bit_clock = bclk_q;
  assign o_output_word_clock = wclk_q;

  // Serial data, MSB first, shifted on the bit clock falling edge
  always_ff @(posedge i_clock) begin
    if (i_reset || !running) begin
      shift_q <= '0;
    end else if (subframe_start) begin
      shift_q <= i_tx_sample;
    end else if (bclk_fall) begin
      shift_q <= {shift_q[SAMPLE_W-2:0], 1'b0};
    end
  end
  assign o_serial_audio_out = running && shift_q[SAMPLE_W-1];

  // Block sync input: count high clocks, arm a restart; arming beats the clear
  always_ff @(posedge i_clock) begin
    if (i_reset || bsync_out) begin
      bs_count_q <= '0;
      bs_pending_q <= 1'b0;
    end else begin
      if (!i_cs_block_sync_pin) begin
        bs_count_q <= '0;
      end else if (bs_count_q != BS_W'(BSYNC_MIN_CLOCKS)) begin
        bs_count_q <= bs_count_q + BS_W'(1);
      end
      if (bs_count_q == BS_W'(BSYNC_MIN_CLOCKS - 1) && i_cs_block_sync_pin) begin
        bs_pending_q <= 1'b1;
      end else if (subframe_start) begin
        bs_pending_q <= 1'b0;
      end
    end
  end

  // Sub-frame position in the channel status block
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      subframe_q <= '0;
    end else if (subframe_start) begin
      if (bs_pending_q || subframe_q == BLK_W'(SUBFRAMES_PER_BLOCK - 1)) begin
        subframe_q <= '0;
      end else begin
        subframe_q <= subframe_q + BLK_W'(1);
      end
    end
  end
  assign o_cs_block_sync_pin = running && (subframe_q == '0);
  assign o_cs_block_sync_pin_oe = bsync_out && strap_done_q;

  // Transmit V, C and U bits sampled on each word clock edge
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_tx_validity <= 1'b0;
      o_tx_cbit <= 1'b0;
      o_tx_ubit <= 1'b0;
    end else if (subframe_start) begin
      o_tx_validity <= av_in && i_audio_or_validity_pin;
      o_tx_cbit <= pc_in && i_pro_flag_or_cbit_pin;
      o_tx_ubit <= eu_in && i_emphasis_or_user_bit_pin;
    end
  end

  // Status pin outputs; strap pins stay released until sampled
  assign o_audio_or_validity_pin = running && i_rx_cs.audio_flag;
  assign o_audio_or_validity_pin_oe = !av_in && strap_done_q;
  assign o_pro_flag_or_cbit_pin = running && i_rx_cs.pro_flag;
  assign o_pro_flag_or_cbit_pin_oe = !pc_in && strap_done_q;
  assign o_emphasis_or_user_bit_pin = running && i_rx_cs.emphasis_strap_pin_none;
  assign o_emphasis_or_user_bit_pin_oe = !eu_in && strap_done_q;
  assign o_original_recording_flag = running && decode_original(i_rx_cs);
  assign o_original_recording_flag_oe = strap_done_q;

  // Line drivers: both low in reset and until the loop has settled
  assign o_line_driver_p = running && i_tx_line_data;
  assign o_line_driver_n = running && !i_tx_line_data;

  // Checks
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_reset);

  sequence settle_run_s;
    (state_q == ST_SETTLE) ##1 (state_q == ST_RUN);
  endsequence

  block_sync_out_a: assert property (
    subframe_start && subframe_q == BLK_W'(SUBFRAMES_PER_BLOCK - 1) && running
    |=> o_cs_block_sync_pin) else $error("block sync not high at block start");
  block_sync_in_a: assert property (
    !bsync_out && i_cs_block_sync_pin [*3] ##0 !subframe_start ##1 subframe_start
    |=> subframe_q == '0) else $error("block sync input did not restart block");
  strap_hold_a: assert property (
    strap_done_q && $past(strap_done_q) |-> $stable(strap_q))
    else $error("strap level changed after capture");
  strap_sample_a: assert property (
    $fell(i_reset) ##0 !strap_done_q |=> strap_q.emphasis_strap_pin == $past(i_emphasis_or_user_bit_pin))
    else $error("strap not sampled at reset exit");
  strap_release_a: assert property (
    $past(i_reset) |-> !o_original_recording_flag_oe && !o_emphasis_or_user_bit_pin_oe)
    else $error("strap pin driven during reset");
  line_low_a: assert property (
    $past(i_reset) |-> !o_line_driver_p && !o_line_driver_n)
    else $error("line drivers not low after reset");
  run_wait_a: assert property (
    o_low_power && !ctrl_q[CTRL_RUN_BIT] && !i_hw_mode_select |=> o_low_power)
    else $error("left low power without run bit");
  settle_gate_a: assert property (
    !running |-> !o_line_driver_p && !o_line_driver_n && !o_serial_audio_out)
    else $error("outputs active before settle");
  settle_time_a: assert property (
    settle_run_s |-> $past(i_pll_locked, 2)) else $error("ran without lock");
  word_clock_a: assert property (
    subframe_start |=> o_output_word_clock != $past(o_output_word_clock))
    else $error("word clock did not toggle");
  original_recording_flag_decode_a: assert property (
    running && (i_rx_cs.category & CAT_GROUP_MASK) != CAT_INVERT_GROUP
    |-> o_original_recording_flag == !i_rx_cs.gen_bit) else $error("original flag wrong");
  id_read_a: assert property (
    apb_setup && i_paddr == IDREV_OFFSET |=> o_prdata[IDREV_ID_LSB +: 4] == ID_CODE &&
    o_prdata[IDREV_REV_LSB +: 4] == REV_CODE) else $error("identity read wrong");
  bs_restart_a: assert property (
    bs_pending_q && subframe_start |=> subframe_q == '0)
    else $error("armed block restart not applied");
  reset_quiet_a: assert property (disable iff (1'b0)
    i_reset && $past(i_reset) |-> !o_line_driver_p && !o_line_driver_n &&
    !o_original_recording_flag_oe && !o_emphasis_or_user_bit_pin_oe) else $error("reset not quiet");

endmodule // trs_top

//--- testbench/trs_board_model.sv
`timescale 1ns/1ps
// Board around the device: strap resistors and external block-sync logic
module trs_board_model (
  // Clock
  input wire logic i_clock,
  // Bench controls
  input wire logic i_pull_emphasis_strap_pin,
  input wire logic i_pull_original_recording_flag,
  input wire logic i_bsync_go,
  // Device pin halves
  input wire logic i_emphasis_strap_pin_out,
  input wire logic i_emphasis_strap_pin_oe,
  input wire logic i_original_recording_flag_out,
  input wire logic i_original_recording_flag_oe,
  input wire logic i_bsync_out,
  input wire logic i_bsync_oe,
  // Resolved pin levels
  output logic o_emphasis_strap_pin_pin,
  output logic o_original_recording_flag_pin,
  output logic o_bsync_pin
);
  logic [1:0] hold_q = 2'h0;
  logic ext_q = 1'h0;
  // Released strap pins fall to their resistor level
  assign o_emphasis_strap_pin_pin = i_emphasis_strap_pin_oe ? i_emphasis_strap_pin_out : i_pull_emphasis_strap_pin;
  assign o_original_recording_flag_pin = i_original_recording_flag_oe ? i_original_recording_flag_out : i_pull_original_recording_flag;
  // External logic drives the sync line low between pulses, never floating
  assign o_bsync_pin = i_bsync_oe ? i_bsync_out : ext_q;
  // Pulse lasts exactly three clocks, the shortest the device must honour
  always @(posedge i_clock) begin
    if (i_bsync_go) begin
      ext_q <= 1'h1;
      hold_q <= 2'h2;
    end else if (hold_q != 2'h0) begin
      hold_q <= hold_q - 2'h1;
    end else begin
      ext_q <= 1'h0;
    end
  end
endmodule // trs_board_model

//--- testbench/trs_top_tb_top.sv
`timescale 1ns/1ps
module trs_top_tb_top;
  import trs_pkg::*;
  // Short serial frame keeps a whole block near twelve thousand cycles
  localparam int HALF = 2;
  localparam int BITS = 8;
  localparam int SUB = 2 * HALF * BITS;
  localparam logic [3:0] ID = 4'h5; // Arbitrary value
  localparam logic [3:0] REV = 4'h3; // Arbitrary value
  localparam logic [32:0] OK = 33'h0;
  localparam logic [32:0] ERR = 33'h100000000;
  // Bench-driven inputs
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic hw = 1'h0, role = 1'h1, lock = 1'h0, ldata = 1'h0, av_in = 1'h0, pc_in = 1'h0;
  logic pull_e = 1'h1, pull_o = 1'h0, go = 1'h0, s_e, s_o;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, r;
  logic [23:0] smp = 24'h0;
  trs_rx_cs_t rx = '0;
  // Device outputs and resolved pins
  logic [31:0] prdata;
  logic pready, pslverr, bs_o, bs_oe, av_o, av_oe, pc_o, pc_oe, eu_o, eu_oe, or_o, or_oe;
  logic wclk, bclk, sdo, lp, ln, txv, txc, txu, lowp, mst, caddr;
  logic eu_pin, or_pin, bs_pin, av_pin, pc_pin;
  trs_strap_t straps;
  int seed = 13, n_errors = 0, n_checks = 0, cycles = 0, n, k;
  logic [32:0] exp_q[$];

  assign av_pin = av_oe ? av_o : av_in;
  assign pc_pin = pc_oe ? pc_o : pc_in;

  trs_top #(.BIT_HALF_CYCLES(HALF), .BITS_PER_SUBFRAME(BITS), .ID_CODE(ID), .REV_CODE(REV)) uut (
    .i_clock(clk), .i_reset(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_hw_mode_select(hw), .i_input_port_role_select(role),
    .i_pll_locked(lock), .i_rx_cs(rx), .i_tx_sample(smp), .i_tx_line_data(ldata),
    .i_cs_block_sync_pin(bs_pin), .o_cs_block_sync_pin(bs_o), .o_cs_block_sync_pin_oe(bs_oe),
    .i_audio_or_validity_pin(av_pin), .o_audio_or_validity_pin(av_o),
    .o_audio_or_validity_pin_oe(av_oe), .i_pro_flag_or_cbit_pin(pc_pin),
    .o_pro_flag_or_cbit_pin(pc_o), .o_pro_flag_or_cbit_pin_oe(pc_oe),
    .i_emphasis_or_user_bit_pin(eu_pin), .o_emphasis_or_user_bit_pin(eu_o),
    .o_emphasis_or_user_bit_pin_oe(eu_oe), .i_original_recording_flag(or_pin),
    .o_original_recording_flag(or_o), .o_original_recording_flag_oe(or_oe),
    .o_output_word_clock(wclk), .o_output_bit_clock(bclk), .o_serial_audio_out(sdo),
    .o_line_driver_p(lp), .o_line_driver_n(ln), .o_tx_validity(txv), .o_tx_cbit(txc),
    .o_tx_ubit(txu), .o_low_power(lowp), .o_input_port_master(mst),
    .o_chip_addr_bit(caddr), .o_hw_straps(straps)
  );

  trs_board_model board (
    .i_clock(clk), .i_pull_emphasis_strap_pin(pull_e), .i_pull_original_recording_flag(pull_o), .i_bsync_go(go),
    .i_emphasis_strap_pin_out(eu_o), .i_emphasis_strap_pin_oe(eu_oe), .i_original_recording_flag_out(or_o), .i_original_recording_flag_oe(or_oe),
    .i_bsync_out(bs_o), .i_bsync_oe(bs_oe), .o_emphasis_strap_pin_pin(eu_pin), .o_original_recording_flag_pin(or_pin),
    .o_bsync_pin(bs_pin)
  );

  // Clock
  initial begin
    forever #2.5 clk = ~clk;
  end

  task automatic chk_word(input string what, input logic [32:0] e, input logic [32:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic chk_pin(input string what, input logic [1:0] e, input logic [1:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // APB master; the expected {pslverr, rdata} is noted for the monitor
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    @(posedge clk);
    while (pready !== 1'h1) @(posedge clk);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // Completed transfers are judged against the oldest note
  always @(posedge clk) begin
    if (psel && penable && pready === 1'h1 && exp_q.size() > 0) begin
      chk_word("apb", exp_q.pop_front(), {pslverr, pwrite ? 32'h0 : prdata});
    end
  end

  // Hang guard, well above the roughly thirteen thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles > 40000) begin
      n_errors++;
      end_of_test();
    end
  end

  function automatic logic [32:0] st(input logic [1:0] s, input logic h);
    return {25'h0, role, h, s_o, s_e, 2'h0, s};
  endfunction

  // Called at a falling edge; returns at the falling edge after a word clock change
  task automatic next_sub(output int c);
    logic w;
    w = wclk;
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (wclk === w && c < 4 * SUB);
  endtask

  task automatic do_reset(input logic h, input logic pe, input logic po);
    @(posedge clk);
    rst <= 1'h1;
    hw <= h;
    pull_e <= pe;
    pull_o <= po;
    ldata <= 1'h1;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk_pin("drivers", 2'h0, {lp, ln});
    chk_pin("strap oe", 2'h0, {eu_oe, or_oe});
    chk_pin("muted", 2'h1, {wclk | sdo, lowp});
    s_e = pe;
    s_o = po;
    @(posedge clk);
    rst <= 1'h0;
  endtask

  initial begin
    do_reset(1'h0, 1'h1, 1'h0);
    apb(1'h0, STATUS_OFFSET, 32'h0, st(2'h0, 1'h0));
    @(negedge clk);
    chk_pin("straps", {s_o, s_e}, straps);
    chk_pin("addr bit", {1'h0, s_e}, {1'h0, caddr});
    chk_pin("role", {1'h0, role}, {1'h0, mst});
    @(posedge clk);
    pull_e <= ~pull_e;
    apb(1'h0, STATUS_OFFSET, 32'h0, st(2'h0, 1'h0));
    apb(1'h0, IDREV_OFFSET, 32'h0, {25'h0, ID, REV});
    apb(1'h0, 8'h0C, 32'h0, ERR);
    apb(1'h1, 8'h10, 32'h1F, ERR);
    apb(1'h1, CTRL_OFFSET, 32'h03, OK);
    apb(1'h0, STATUS_OFFSET, 32'h0, st(2'h1, 1'h0));
    @(negedge clk);
    chk_pin("settling", 2'h0, {lp, wclk});
    @(posedge clk);
    lock <= 1'h1;
    repeat (SETTLE_CYCLES + 2) @(posedge clk);
    apb(1'h0, STATUS_OFFSET, 32'h0, st(2'h2, 1'h0));
    // Output roles, line drivers and copy flag with random receive data
    repeat (8) begin
      @(posedge clk);
      r = $random(seed);
      rx <= r[11:0];
      ldata <= r[13];
      smp <= r[31:8];
      @(negedge clk);
      chk_pin("audio", {1'h1, rx.audio_flag}, {av_oe, av_o});
      chk_pin("pro", {1'h1, rx.pro_flag}, {pc_oe, pc_o});
      chk_pin("emphasis_strap_pin", {1'h1, rx.emphasis_strap_pin_none}, {eu_oe, eu_o});
      chk_pin("original_recording_flag", {1'h1, ((rx.category & CAT_GROUP_MASK) == CAT_INVERT_GROUP) ?
        rx.gen_bit : !rx.gen_bit}, {or_oe, or_o});
      chk_pin("line", {r[13], !r[13]}, {lp, ln});
    end
    // Transmit bits taken from the pins at sub-frame start
    apb(1'h1, CTRL_OFFSET, 32'h1F, OK);
    repeat (4) begin
      @(posedge clk);
      r = $random(seed);
      av_in <= r[0];
      pc_in <= r[1];
      pull_e <= r[2];
      @(negedge clk);
      next_sub(n);
      next_sub(n);
      chk_pin("tx bits", {r[0], r[1]}, {txv, txc});
      chk_pin("ubit", {1'h0, r[2]}, {eu_oe, txu});
    end
    // Outside sync pulse, then watch the block boundary it set
    apb(1'h1, CTRL_OFFSET, 32'h01, OK);
    @(negedge clk);
    next_sub(n);
    @(posedge clk);
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
    @(negedge clk);
    next_sub(n);
    apb(1'h1, CTRL_OFFSET, 32'h03, OK);
    @(negedge clk);
    k = 0;
    do begin
      next_sub(n);
      k++;
      if (k > 1) chk_word("word clock", 33'(SUB), 33'(n));
    end while (bs_pin !== 1'h1 && k < 500);
    chk_word("block start", 33'(SUBFRAMES_PER_BLOCK), 33'(k));
    n = 0;
    while (bs_pin === 1'h1 && n < 4 * SUB) begin
      @(negedge clk);
      n++;
    end
    chk_word("sync width", 33'(SUB), 33'(n));
    // Bit clock and data framing just after a word clock change
    next_sub(n);
    chk_pin("bit clock", 2'h0, {1'h0, bclk});
    chk_pin("serial msb", {1'h0, smp[23]}, {1'h0, sdo});
    repeat (HALF) @(negedge clk);
    chk_pin("bit clock", 2'h1, {1'h0, bclk});
    repeat (HALF) @(negedge clk);
    chk_pin("serial bit", {1'h0, smp[22]}, {1'h0, sdo});
    // Hardware mode refuses control port writes
    do_reset(1'h1, 1'h0, 1'h1);
    role <= 1'h0;
    repeat (SETTLE_CYCLES + 4) @(posedge clk);
    apb(1'h0, STATUS_OFFSET, 32'h0, st(2'h2, 1'h1));
    apb(1'h1, CTRL_OFFSET, 32'h00, ERR);
    @(negedge clk);
    chk_pin("hw addr bit", 2'h0, {1'h0, caddr});
    chk_pin("slave role", 2'h0, {1'h0, mst});
    end_of_test();
  end
endmodule // trs_top_tb_top
